//--- hdl/ppg_top.v
// Purpose: group one parallel block, ports one, two and three
// Assumes: register port and pins synchronous to ref_clk
// Notes:   pin outputs are registered, one cycle behind state
//
// Overview of operation
// - Decode E4, E5 data, E7 configuration.
// - Bits 6,5 port one mode; 4 direction.
// - Bit 2 port two mode; 1 direction.
// - Port one lines are inverted always.
// - Strobed input: bit3 irq, bit4 strobe, bit5 full.
// - Strobed input: bit6 always input; 7 unused.
// - Strobed output: bit3 irq, bit6 ack, bit7 full.
// - Strobed output: bit4 input or bit5 output.
// - Bidirectional: bits 3-7 handshake; 0,1 or 2 general.
// - Bidirectional drives outward while acknowledge low.
// - Port two input: bit0 irq, bit1 full, bit2 strobe.
// - Port two output: bit0 irq, bit1 full, bit2 ack.
// - Port three never splits four and four.
// - Routed requests drive shared active-low line.
`include "ppg_defs.vh"

module ppg_top (
	input  wire       ref_clk,
	input  wire       srst,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire [7:0] p1_in,
	output reg  [7:0] p1_out,
	output reg        p1_oe,
	input  wire [7:0] p2_in,
	output reg  [7:0] p2_out,
	output reg        p2_oe,
	input  wire [7:0] p3_in,
	output reg  [7:0] p3_out,
	output reg  [7:0] p3_oe,
	output reg        shared_irq_line_n
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------

	// Address match qualified by a strobe
	function hit;
		input [7:0] addr;
		input [7:0] want;
		input       stb;
		begin
			hit = stb & (addr == want);
		end
	endfunction

	// Port one mode from the configuration word
	function [1:0] p1_mode;
		input [7:0] cfg;
		begin
			if (cfg[`PPG_CFG_P1_BIDI])
				p1_mode = `PPG_P1_BIDIR;
			else if (cfg[`PPG_CFG_P1_STRB])
				p1_mode = `PPG_P1_STROBED;
			else
				p1_mode = `PPG_P1_PLAIN;
		end
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	reg  [7:0] cfg;          // Group configuration word
	reg  [1:0] route;        // Interrupt routing enables
	reg  [7:0] p1_latch;     // Port one output latch, true sense
	reg  [7:0] p2_latch;     // Port two output latch
	reg  [7:0] p3_latch;     // Port three output latch
	reg  [7:0] next_p1_out;
	reg        next_p1_oe;
	reg  [7:0] next_p2_out;
	reg        next_p2_oe;
	reg  [7:0] next_p3_out;
	reg  [7:0] next_p3_oe;
	reg  [7:0] next_rdata;
	wire [1:0] m1;           // Decoded port one mode
	wire       p2_strb;      // Port two in strobed mode
	wire       p1_in_dir;    // Port one input in plain/strobed
	wire       p2_in_dir;    // Port two input direction
	wire       cfg_wr;
	wire       p1_wr;
	wire       p1_rd;
	wire       p2_wr;
	wire       p2_rd;
	wire       p3_wr;
	wire [7:0] p1_pins;      // Port one lines in true sense
	wire [7:0] h1_data;
	wire       h1_ibf;
	wire       h1_obf;
	wire       h1_irq;
	wire [7:0] h2_data;
	wire       h2_ibf;
	wire       h2_obf;
	wire       h2_irq;

	assign m1        = p1_mode(cfg);
	// Host must keep port two plain in bidirectional mode; the
	// strobed port two is gated off there so a slip is harmless
	assign p2_strb   = cfg[`PPG_CFG_P2_STRB] &
	                   (m1 != `PPG_P1_BIDIR);
	assign p1_in_dir = cfg[`PPG_CFG_P1_DIR];
	assign p2_in_dir = cfg[`PPG_CFG_P2_DIR];
	assign cfg_wr    = hit(reg_addr, `PPG_ADDR_CFG, reg_wr) &
	                   reg_wdata[`PPG_CFG_LOAD];
	assign p1_wr     = hit(reg_addr, `PPG_ADDR_P1, reg_wr);
	assign p1_rd     = hit(reg_addr, `PPG_ADDR_P1, reg_rd);
	assign p2_wr     = hit(reg_addr, `PPG_ADDR_P2, reg_wr);
	assign p2_rd     = hit(reg_addr, `PPG_ADDR_P2, reg_rd);
	assign p3_wr     = hit(reg_addr, `PPG_ADDR_P3, reg_wr);
	assign p1_pins   = ~p1_in;

	// ------------------------------------------------------------
	// Handshake channels
	// ------------------------------------------------------------

	// Port one: strobe on bit 4, acknowledge on bit 6
	ppg_hs u_hs1 (
		.ref_clk          (ref_clk),
		.srst             (srst),
		.clr              (cfg_wr),
		.in_en            ((m1 == `PPG_P1_STROBED & p1_in_dir) |
		                   (m1 == `PPG_P1_BIDIR)),
		.out_en           ((m1 == `PPG_P1_STROBED & ~p1_in_dir) |
		                   (m1 == `PPG_P1_BIDIR)),
		.load_strobe_n    (p3_in[4]),
		.ack_n            (p3_in[6]),
		.pin_data         (p1_pins),
		.host_rd          (p1_rd),
		.host_wr          (p1_wr),
		.rx_data          (h1_data),
		.input_buffer_full(h1_ibf),
		.obf              (h1_obf),
		.irq              (h1_irq)
	);

	// Port two: strobe and acknowledge share bit 2
	ppg_hs u_hs2 (
		.ref_clk          (ref_clk),
		.srst             (srst),
		.clr              (cfg_wr),
		.in_en            (p2_strb & p2_in_dir),
		.out_en           (p2_strb & ~p2_in_dir),
		.load_strobe_n    (p3_in[2]),
		.ack_n            (p3_in[2]),
		.pin_data         (p2_in),
		.host_rd          (p2_rd),
		.host_wr          (p2_wr),
		.rx_data          (h2_data),
		.input_buffer_full(h2_ibf),
		.obf              (h2_obf),
		.irq              (h2_irq)
	);

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------

	// Configuration only loads with its top bit set; a new mode
	// also clears both channels' flags and the latches
	always @(posedge ref_clk) begin
		if (srst) begin
			cfg      <= `PPG_CFG_RESET;
			route    <= 2'h0;
			p1_latch <= 8'h00;
			p2_latch <= 8'h00;
			p3_latch <= 8'h00;
		end else begin
			if (cfg_wr) begin
				cfg      <= reg_wdata;
				p1_latch <= 8'h00;
				p2_latch <= 8'h00;
				p3_latch <= 8'h00;
			end else begin
				if (p1_wr)
					p1_latch <= reg_wdata;
				if (p2_wr)
					p2_latch <= reg_wdata;
				if (p3_wr)
					p3_latch <= reg_wdata;
			end
			if (hit(reg_addr, `PPG_ADDR_ROUTE, reg_wr))
				route <= reg_wdata[1:0];
		end
	end

	// ------------------------------------------------------------
	// Port one and two pin drive
	// ------------------------------------------------------------
	always @* begin
		// Port one lines carry the inverse of the latch
		next_p1_out = ~p1_latch;
		case (m1)
			`PPG_P1_PLAIN,
			`PPG_P1_STROBED: begin
				next_p1_oe = ~p1_in_dir;
			end
			`PPG_P1_BIDIR: begin
				// Acknowledge low turns the drivers outward
				next_p1_oe = ~p3_in[6];
			end
			default: begin
				next_p1_oe = 1'b0;
			end
		endcase
		next_p2_out = p2_latch;
		next_p2_oe  = ~p2_in_dir;
	end

	// ------------------------------------------------------------
	// Port three pin drive
	// ------------------------------------------------------------

	// Unused or input bits stay undriven; general outputs come
	// from the port three latch
	always @* begin
		next_p3_out = 8'h00;
		next_p3_oe  = 8'h00;
		if (m1 == `PPG_P1_PLAIN & ~p2_strb) begin
			// Whole port one way: bit 3 picks the direction, so a
			// four-and-four split cannot be set up
			next_p3_out = p3_latch;
			next_p3_oe  = {8{~cfg[`PPG_CFG_P3_SEL]}};
		end else begin
			// Lower three bits
			if (p2_strb) begin
				next_p3_out[0] = h2_irq;
				next_p3_oe[0]  = 1'b1;
				next_p3_oe[1]  = 1'b1;
				if (p2_in_dir)
					next_p3_out[1] = h2_ibf;
				else
					next_p3_out[1] = ~h2_obf;
			end else if (~cfg[`PPG_CFG_P3_SEL]) begin
				// Bits 0,1 general outputs, bit 2 unused
				next_p3_out[1:0] = p3_latch[1:0];
				next_p3_oe[1:0]  = 2'h3;
			end
			// Upper five bits
			case (m1)
				`PPG_P1_STROBED: begin
					next_p3_out[3] = h1_irq;
					next_p3_oe[3]  = 1'b1;
					if (p1_in_dir) begin
						// Bit 6 input only, bit 7 idle
						next_p3_out[5] = h1_ibf;
						next_p3_oe[5]  = 1'b1;
					end else begin
						next_p3_out[7] = ~h1_obf;
						next_p3_oe[7]  = 1'b1;
						// Bit 5 out only when bit 4 not in use
						if (~cfg[`PPG_CFG_P3_SEL]) begin
							next_p3_out[5] = p3_latch[5];
							next_p3_oe[5]  = 1'b1;
						end
					end
				end
				`PPG_P1_BIDIR: begin
					next_p3_out[3] = h1_irq;
					next_p3_out[5] = h1_ibf;
					next_p3_out[7] = ~h1_obf;
					next_p3_oe     = next_p3_oe | 8'ha8;
				end
				default: begin
					// Port one plain: upper bits general, one way
					next_p3_out[7:3] = p3_latch[7:3];
					next_p3_oe[7:3]  = {5{~cfg[`PPG_CFG_P3_SEL]}};
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------

	// Strobed inputs return the captured byte, plain inputs the
	// live lines, outputs their latch; unmapped reads give zero
	always @* begin
		next_rdata = 8'h00;
		case (reg_addr)
			`PPG_ADDR_P1: begin
				if (m1 == `PPG_P1_PLAIN)
					next_rdata = p1_in_dir ? p1_pins : p1_latch;
				else if (m1 == `PPG_P1_BIDIR | p1_in_dir)
					next_rdata = h1_data;
				else
					next_rdata = p1_latch;
			end
			`PPG_ADDR_P2: begin
				if (~p2_in_dir)
					next_rdata = p2_latch;
				else if (p2_strb)
					next_rdata = h2_data;
				else
					next_rdata = p2_in;
			end
			`PPG_ADDR_P3: begin
				// Input bits 6 and 4 and 2 show here when freed
				next_rdata = (p3_oe & p3_out) | (~p3_oe & p3_in);
			end
			`PPG_ADDR_STATUS: begin
				next_rdata = {2'h0, h2_irq, h2_obf, h2_ibf,
				              h1_irq, h1_obf, h1_ibf};
			end
			`PPG_ADDR_ROUTE: begin
				next_rdata = {6'h00, route};
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------

	// Every pin comes from a flop, so pins lag state by one cycle;
	// reset holds all lines undriven and the shared line high
	always @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata         <= 8'h00;
			p1_out            <= 8'hff;
			p1_oe             <= 1'b0;
			p2_out            <= 8'h00;
			p2_oe             <= 1'b0;
			p3_out            <= 8'h00;
			p3_oe             <= 8'h00;
			shared_irq_line_n <= 1'b1;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
			p1_out    <= next_p1_out;
			p1_oe     <= next_p1_oe;
			p2_out    <= next_p2_out;
			p2_oe     <= next_p2_oe;
			p3_out    <= next_p3_out;
			p3_oe     <= next_p3_oe;
			// Routed, active-low; plain modes never request
			shared_irq_line_n <= ~((h1_irq & route[`PPG_ROUTE_P1] &
			                        (m1 != `PPG_P1_PLAIN)) |
			                       (h2_irq & route[`PPG_ROUTE_P2] &
			                        p2_strb));
		end
	end

endmodule

//--- common/ppg_defs.vh
// Purpose: constants of the grouped parallel port block
// Assumes: byte wide register port, one clock
// Notes:   definitions only
`ifndef PPG_DEFS_VH
`define PPG_DEFS_VH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define PPG_ADDR_STATUS 8'he2
`define PPG_ADDR_ROUTE  8'he3
`define PPG_ADDR_P1     8'he4
`define PPG_ADDR_P2     8'he5
`define PPG_ADDR_P3     8'he6
`define PPG_ADDR_CFG    8'he7

// ------------------------------------------------------------
// Group configuration word fields
// ------------------------------------------------------------
`define PPG_CFG_LOAD    7
`define PPG_CFG_P1_BIDI 6
`define PPG_CFG_P1_STRB 5
`define PPG_CFG_P1_DIR  4
`define PPG_CFG_P3_SEL  3
`define PPG_CFG_P2_STRB 2
`define PPG_CFG_P2_DIR  1

// Plain mode, every port an input
`define PPG_CFG_RESET   8'h9b

// Interrupt route register fields
`define PPG_ROUTE_P1    0
`define PPG_ROUTE_P2    1

// Port one modes after decode
`define PPG_P1_PLAIN    2'h0
`define PPG_P1_STROBED  2'h1
`define PPG_P1_BIDIR    2'h2

`endif

//--- hdl/ppg_hs.v
// Purpose: strobe / acknowledge handshake for one strobed port
// Assumes: all pins synchronous to ref_clk
// Notes:   input and output halves may run together

module ppg_hs (
	input  wire       ref_clk,
	input  wire       srst,
	input  wire       clr,
	input  wire       in_en,
	input  wire       out_en,
	input  wire       load_strobe_n,
	input  wire       ack_n,
	input  wire [7:0] pin_data,
	input  wire       host_rd,
	input  wire       host_wr,
	output reg  [7:0] rx_data,
	output reg        input_buffer_full,
	output reg        obf,
	output wire       irq
);

	reg  prev_stb;   // Strobe level one cycle back
	reg  prev_ack;   // Acknowledge level one cycle back
	reg  in_irq;     // Request from the receive half
	reg  out_irq;    // Request from the send half
	wire stb_fall;
	wire stb_rise;
	wire ack_fall;
	wire ack_rise;

	assign stb_fall = in_en & prev_stb & ~load_strobe_n;
	assign stb_rise = in_en & ~prev_stb & load_strobe_n;
	assign ack_fall = out_en & prev_ack & ~ack_n;
	assign ack_rise = out_en & ~prev_ack & ack_n;
	assign irq      = in_irq | out_irq;

	// ------------------------------------------------------------
	// Edge history
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			prev_stb <= 1'b1;
			prev_ack <= 1'b1;
		end else begin
			prev_stb <= load_strobe_n;
			prev_ack <= ack_n;
		end
	end

	// ------------------------------------------------------------
	// Flags; an arriving edge beats the host access that clears
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (srst | clr) begin
			rx_data           <= 8'h00;
			input_buffer_full <= 1'b0;
			obf               <= 1'b0;
			in_irq            <= 1'b0;
			out_irq           <= 1'b0;
		end else begin
			// Falling strobe captures the lines
			if (stb_fall)
				rx_data <= pin_data;
			if (stb_fall)
				input_buffer_full <= 1'b1;
			else if (host_rd)
				input_buffer_full <= 1'b0;
			// Request once the strobe ends with data held
			if (stb_rise & input_buffer_full)
				in_irq <= 1'b1;
			else if (host_rd)
				in_irq <= 1'b0;
			// Host write fills the send buffer
			if (host_wr & out_en)
				obf <= 1'b1;
			else if (ack_fall)
				obf <= 1'b0;
			// Request once the peripheral has taken the byte
			if (ack_rise & ~obf)
				out_irq <= 1'b1;
			else if (host_wr)
				out_irq <= 1'b0;
		end
	end

endmodule

//--- test/ppg_props.sv
// Purpose: port-level checks of the grouped parallel port block
// Assumes: one clock, synchronous active-high reset
// Notes:   shadows the config word to know which pin map applies
`include "ppg_defs.vh"

module ppg_props (
	input logic       ref_clk,
	input logic       srst,
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic       reg_wr,
	input logic       reg_rd,
	input logic [7:0] reg_rdata,
	input logic [7:0] p1_in,
	input logic [7:0] p1_out,
	input logic       p1_oe,
	input logic [7:0] p2_in,
	input logic [7:0] p2_out,
	input logic       p2_oe,
	input logic [7:0] p3_in,
	input logic [7:0] p3_out,
	input logic [7:0] p3_oe,
	input logic       shared_irq_line_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cfg; // Shadow config, pins follow it one edge late
	// ----------------------------------------------------------
	// Shadow of loads; bit 7 clear is not a load
	// ----------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst)
			cfg <= `PPG_CFG_RESET;
		else if (reg_wr && reg_addr == `PPG_ADDR_CFG && reg_wdata[7])
			cfg <= reg_wdata;
	end
	default clocking dcb @(posedge ref_clk); endclocking
	default disable iff (srst);
	chk_reset_idle:
	assert property (disable iff (1'b0) srst |=> !p1_oe && !p2_oe &&
		p3_oe == 8'h00 && shared_irq_line_n && p1_out == 8'hff)
		else $error("outputs not idle after reset");
	chk_read_quiet:
	assert property (!reg_rd || reg_addr >= `PPG_ADDR_CFG ||
		reg_addr < `PPG_ADDR_STATUS |=> reg_rdata == 8'h00)
		else $error("read data not zero");
	chk_p1_invert:
	assert property (reg_wr && reg_addr == `PPG_ADDR_P1 |=> ##1
		p1_out == ~$past(reg_wdata, 2))
		else $error("port one drive not inverted latch");
	chk_p3_whole:
	assert property ($past(cfg[6:5] == 2'b00 && !cfg[2]) |->
		p3_oe == {8{!$past(cfg[3])}})
		else $error("port three not one direction");
	chk_strb_in_map:
	assert property ($past(cfg[6:4] == 3'b011) |-> p3_oe[7:3] == 5'b00101)
		else $error("strobed input pin map wrong");
	chk_strb_out_map:
	assert property ($past(cfg[6:4] == 3'b010) |-> p3_oe[7:6] == 2'b10 &&
		!p3_oe[4] && p3_oe[3] && p3_oe[5] == !$past(cfg[3]))
		else $error("strobed output pin map wrong");
	chk_bidir_map:
	assert property ($past(cfg[6]) |-> p3_oe[7:3] == 5'b10101 &&
		!p3_oe[2] && p3_oe[1:0] == {2{!$past(cfg[3])}})
		else $error("bidirectional pin map wrong");
	chk_bidir_dir:
	assert property ($past(cfg[6]) |-> p1_oe == !$past(p3_in[6]))
		else $error("port one direction not from acknowledge");
	chk_shared_src:
	assert property (!shared_irq_line_n |->
		(p3_out[3] && p3_oe[3]) || (p3_out[0] && p3_oe[0]))
		else $error("shared line low with no request");
	cov_p1_irq: cover property (cfg[6:4] == 3'b011 && p3_out[3]);
	cov_bidir: cover property (cfg[6] && p1_oe);
	cov_p2_irq: cover property (cfg[2] && p3_out[0]);
endmodule

bind ppg_top ppg_props u_props (.ref_clk, .srst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .p1_in, .p1_out, .p1_oe, .p2_in,
	.p2_out, .p2_oe, .p3_in, .p3_out, .p3_oe, .shared_irq_line_n);

//--- test/ppg_periph.sv
// Purpose: peripheral model on the port lines of the parallel block
// Assumes: handshake lines idle high, strobes active low
// Notes:   released data lines show the inverse of the last value
module ppg_periph (
	input  logic       ref_clk,
	output logic [7:0] p1_in,
	output logic [7:0] p2_in,
	output logic [7:0] p3_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle: handshake lines high
	initial begin
		p1_in = 8'h00;
		p2_in = 8'h00;
		p3_in = 8'hff;
	end
	// Present bytes; port one lines carry the inverted sense
	task automatic put(input logic [7:0] d1, input logic [7:0] d2);
		@(posedge ref_clk);
		p1_in <= ~d1;
		p2_in <= d2;
	endtask
	// One-cycle low pulse; data held across the fall, then released
	task automatic pulse(input int b, input logic [7:0] d1,
		input logic [7:0] d2);
		put(d1, d2);
		p3_in[b] <= 1'b0;
		@(posedge ref_clk);
		p3_in[b] <= 1'b1;
		p1_in <= d1;
		p2_in <= ~d2;
	endtask
	// Hold one port three line at a level
	task automatic level(input int b, input logic v);
		@(posedge ref_clk);
		p3_in[b] <= v;
	endtask
endmodule

//--- test/parallel_port_group_handshake_tb.sv
// Purpose: self-checking bench of the grouped parallel port block
// Assumes: 10 MHz clock, synchronous reset held five cycles
// Notes:   pins are judged two edges after their cause
`include "ppg_defs.vh"

module parallel_port_group_handshake_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk;
	logic       srst;
	logic       reg_wr;
	logic       reg_rd;
	logic       p1_oe;
	logic       p2_oe;
	logic       shared_irq_line_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [7:0] p1_in;
	logic [7:0] p1_out;
	logic [7:0] p2_in;
	logic [7:0] p2_out;
	logic [7:0] p3_in;
	logic [7:0] p3_out;
	logic [7:0] p3_oe;
	logic [7:0] d;
	int         mismatches;
	int         samples_checked;
	ppg_top u_dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .p1_in, .p1_out, .p1_oe, .p2_in, .p2_out,
		.p2_oe, .p3_in, .p3_out, .p3_oe, .shared_irq_line_n);
	ppg_periph u_per (.ref_clk, .p1_in, .p2_in, .p3_in);
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;
	// ----------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------
	// Wide enough for an enable bit packed beside a full byte
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		samples_checked++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the read edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task automatic t_reset;
		tick(1);
		chk(p1_out, 8'hff);
		chk({p1_oe, p2_oe, shared_irq_line_n}, 8'h01);
		chk(p3_oe, 8'h00);
		$display("reset test done");
	endtask
	// Plain outputs, ignored load, then plain inputs
	task automatic t_plain;
		wr(`PPG_ADDR_CFG, 8'h80);
		wr(`PPG_ADDR_P1, 8'ha5);
		wr(`PPG_ADDR_P2, 8'h3c);
		wr(`PPG_ADDR_P3, 8'h69);
		wr(`PPG_ADDR_CFG, 8'h1b);
		tick(2);
		chk(p1_out, 8'h5a);
		chk(p1_oe, 8'h01);
		chk({p2_oe, p2_out}, 9'h13c);
		chk(p3_oe, 8'hff);
		chk(p3_out, 8'h69);
		rd(`PPG_ADDR_P1, d);
		chk(d, 8'ha5);
		rd(`PPG_ADDR_P3, d);
		chk(d, 8'h69);
		rd(8'he1, d);
		chk(d, 8'h00);
		rd(`PPG_ADDR_CFG, d);
		chk(d, 8'h00);
		wr(`PPG_ADDR_CFG, 8'h9b);
		u_per.put(8'hc3, 8'h96);
		tick(2);
		chk({p1_oe, p2_oe}, 8'h00);
		rd(`PPG_ADDR_P1, d);
		chk(d, 8'hc3);
		rd(`PPG_ADDR_P2, d);
		chk(d, 8'h96);
		$display("plain test done");
	endtask
	task automatic t_p1_in;
		wr(`PPG_ADDR_ROUTE, 8'h01);
		wr(`PPG_ADDR_CFG, 8'hb8);
		u_per.pulse(4, 8'h6d, 8'h00);
		tick(2);
		chk({p3_out[5], p3_out[3]}, 8'h03);
		chk(shared_irq_line_n, 8'h00);
		chk(p3_oe[7:6], 8'h00);
		// Status is a plain look, it must not clear the flags
		rd(`PPG_ADDR_STATUS, d);
		chk(d, 8'h05);
		rd(`PPG_ADDR_P1, d);
		chk(d, 8'h6d);
		tick(2);
		chk({p3_out[5], p3_out[3], shared_irq_line_n}, 8'h01);
		$display("port one strobed input test done");
	endtask
	task automatic t_p1_out;
		wr(`PPG_ADDR_CFG, 8'ha0);
		wr(`PPG_ADDR_P1, 8'he1);
		tick(2);
		chk({p3_out[7], p3_oe[5]}, 8'h01);
		chk(p1_out, 8'h1e);
		u_per.pulse(6, 8'h00, 8'h00);
		tick(2);
		chk({p3_out[7], p3_out[3]}, 8'h03);
		$display("port one strobed output test done");
	endtask
	task automatic t_port_two;
		wr(`PPG_ADDR_ROUTE, 8'h02);
		wr(`PPG_ADDR_CFG, 8'h86);
		u_per.pulse(2, 8'h00, 8'h5c);
		tick(2);
		chk({p3_out[1], p3_out[0], shared_irq_line_n}, 8'h06);
		rd(`PPG_ADDR_P2, d);
		chk(d, 8'h5c);
		wr(`PPG_ADDR_CFG, 8'h84);
		wr(`PPG_ADDR_P2, 8'h77);
		tick(2);
		chk({p3_out[1], p2_out}, 9'h077);
		u_per.pulse(2, 8'h00, 8'h00);
		tick(2);
		chk({p3_out[1:0], shared_irq_line_n}, 8'h06);
		$display("port two strobed test done");
	endtask
	// Port two left plain while port one is bidirectional
	task automatic t_bidir;
		wr(`PPG_ADDR_CFG, 8'hc0);
		u_per.level(6, 1'b0);
		tick(2);
		chk({p1_oe, p3_oe[1:0]}, 8'h07);
		u_per.level(6, 1'b1);
		tick(2);
		chk(p1_oe, 8'h00);
		// Select bit set: bits 0 and 1 give way to the bit 2 input
		wr(`PPG_ADDR_CFG, 8'hc8);
		tick(2);
		chk(p3_oe, 8'ha8);
		$display("bidirectional test done");
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------
	// Main sequence and watchdog (tests need under a hundred cycles)
	// ----------------------------------------------------------
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		mismatches = 0;
		samples_checked = 0;
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		t_reset;
		t_plain;
		t_p1_in;
		t_p1_out;
		t_port_two;
		t_bidir;
		summarize;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		summarize;
	end
endmodule
